// >>> verilog/hic_pkg.sv
// package for the host interface configuration register block
package hic_pkg;
  // ----------------------------------------------------------------
  // register byte addresses (low 16 bits of haddr decoded)
  // ----------------------------------------------------------------
  localparam logic [15:0] HIC_CFG0_ADDR = 16'hff94;
  localparam logic [15:0] HIC_CFG1_ADDR = 16'hff95;
  localparam logic [15:0] HIC_PCMD_ADDR = 16'hff98;
  localparam logic [15:0] HIC_STAT_ADDR = 16'hff9c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int C0_SHADOW     = 0;
  localparam int C0_HREQ_LO    = 1;
  localparam int C0_DYN_EN     = 3;
  localparam int C0_DYN_HALF   = 4;
  localparam int C0_ULTRA_LO   = 5;
  localparam int C1_ULTRA3     = 0;
  localparam int C1_CLEAR_REG  = 1;
  localparam int C1_UNMASK     = 2;
  localparam int C1_UNUSED     = 3;
  localparam int C1_FLUSH      = 4;
  localparam int C1_UDMA_KEEP  = 5;
  localparam int C1_STAT_OFF   = 6;
  localparam int C1_DMA_SUSP   = 7;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG0_RST      = 8'h00;
  localparam logic [7:0] CFG1_RST      = 8'h00;
  localparam logic [7:0] CFG1_STORE_MK = 8'he5;

  // ----------------------------------------------------------------
  // host request threshold codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HIC_REQ_TWO_THIRD = 2'b00,
    HIC_REQ_HALF      = 2'b01,
    HIC_REQ_ONE_THIRD = 2'b10,
    HIC_REQ_FULL_M2   = 2'b11
  } hic_req_t;

  localparam int HIC_FULL_MARGIN = 2;
  localparam int HIC_PCMD_BYTES  = 12;

  // ahb transfer codes
  localparam logic [1:0] HIC_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HIC_HTRANS_SEQ    = 2'b11;
endpackage : hic_pkg

// >>> verilog/hic_thresh.sv
// fifo fill level comparator for host request and high priority
`timescale 1ns/10ps
module hic_thresh
  import hic_pkg::*;
#(
  parameter int FIFO_DEPTH = 96,
  parameter int LVL_W      = 8
) (
  // configuration
  input  wire logic [1:0]       req_code,
  input  wire logic             dyn_en,
  input  wire logic             dyn_half,
  // occupancy
  input  wire logic [LVL_W-1:0] level,
  // results
  output logic                  req_hit,
  output logic                  dyn_prio
);
  localparam logic [LVL_W-1:0] L_TWO_THIRD = LVL_W'((2 * FIFO_DEPTH) / 3);
  localparam logic [LVL_W-1:0] L_HALF      = LVL_W'(FIFO_DEPTH / 2);
  localparam logic [LVL_W-1:0] L_ONE_THIRD = LVL_W'(FIFO_DEPTH / 3);
  localparam logic [LVL_W-1:0] L_FULL_M2   = LVL_W'(FIFO_DEPTH - HIC_FULL_MARGIN);

  logic [LVL_W-1:0] req_lvl;
  logic [LVL_W-1:0] n_lvl;

  always_comb begin
    unique case (hic_req_t'(req_code))
      HIC_REQ_TWO_THIRD: req_lvl = L_TWO_THIRD;
      HIC_REQ_HALF:      req_lvl = L_HALF;
      HIC_REQ_ONE_THIRD: req_lvl = L_ONE_THIRD;
      HIC_REQ_FULL_M2:   req_lvl = L_FULL_M2;
    endcase
    n_lvl    = dyn_half ? L_HALF : L_ONE_THIRD;                    // see R5
    req_hit  = (level >= req_lvl);                                 // see R7
    dyn_prio = dyn_en && (level <= n_lvl);                         // see R6
  end
endmodule : hic_thresh

// >>> verilog/hic_config.sv
// host interface configuration registers with ahb-lite slave
//
// Function
// R1: microcontroller reads host packet command bytes
// R2: packet accepted only in mode and transfer
// R3: ultra bits in cfg0[7:5] and cfg1[0]
// R4: ultra bits extend ultra engine timing limits
// R5: cfg0 bit4 picks threshold third or half
// R6: cfg0 bit3 enables dynamic high priority
// R7: cfg0 bits2:1 select host request level
// R8: cfg0 bit0 enables single drive shadowing
// R9: cfg1 bit7 allows generic dma suspend
// R10: cfg1 bit6 disables statistical high priority
// R11: cfg1 bit5 controls ultra switch off
// R12: bit5 zero clears ultra enable at end
// R13: writing cfg1 bit4 flushes command pointer
// R14: writing cfg1 bit1 clears counter, size store
// R15: thresholds evaluated every clock against level
// R16: cfg1 bit3 reads zero, writes ignored
`timescale 1ns/10ps
module hic_config
  import hic_pkg::*;
#(
  parameter int FIFO_DEPTH = 96,
  parameter int LVL_W      = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // host side packet bytes
  input  wire logic             pkt_wr,
  input  wire logic [7:0]       pkt_byte,
  input  wire logic             atapi_mode,
  input  wire logic             xfer_started,
  // transfer status from the host engine
  input  wire logic             xfer_end,
  input  wire logic [LVL_W-1:0] fifo_level,
  // outputs to the host interface
  output logic [3:0]            ultra_ctrl,
  output logic                  shadow_en,
  output logic                  dma_susp_en,
  output logic                  stat_prio_en,
  output logic                  ultra_ata_clr,
  output logic                  seq_clear,
  output logic                  unmask_dtei,
  output logic                  host_req,
  output logic                  host_hi_prio
);
  // ----------------------------------------------------------------
  // ahb address phase capture
  // ----------------------------------------------------------------
  logic        ap_valid_r, ap_valid_nxt;
  logic        ap_write_r, ap_write_nxt;
  logic [15:0] ap_addr_r,  ap_addr_nxt;

  always_comb begin
    ap_valid_nxt = 1'b0;
    ap_write_nxt = ap_write_r;
    ap_addr_nxt  = ap_addr_r;
    if (hready && hsel && htrans[1]) begin
      ap_valid_nxt = 1'b1;
      ap_write_nxt = hwrite;
      ap_addr_nxt  = {haddr[15:2], 2'b00};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 16'h0000;
    end else begin
      ap_valid_r <= ap_valid_nxt;
      ap_write_r <= ap_write_nxt;
      ap_addr_r  <= ap_addr_nxt;
    end
  end

  // byte lanes of the two config bytes inside the ff94 word
  logic wr_cfg;
  logic rd_pcmd;
  assign wr_cfg    = ap_valid_r && ap_write_r && (ap_addr_r == HIC_CFG0_ADDR);
  assign rd_pcmd   = ap_valid_r && !ap_write_r && (ap_addr_r == HIC_PCMD_ADDR);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] cfg0_r, cfg0_nxt;
  logic [7:0] cfg1_r, cfg1_nxt;
  logic       flush_r, flush_nxt;
  logic       clr_r, clr_nxt;

  always_comb begin
    cfg0_nxt  = cfg0_r;
    cfg1_nxt  = cfg1_r;
    flush_nxt = 1'b0;
    clr_nxt   = 1'b0;
    if (wr_cfg) begin
      cfg0_nxt  = hwdata[7:0];                                      // see R3
      // strobe bits and the unused bit are not stored
      cfg1_nxt  = hwdata[15:8] & CFG1_STORE_MK;                     // see R16
      flush_nxt = hwdata[8 + C1_FLUSH];                             // see R13
      clr_nxt   = hwdata[8 + C1_CLEAR_REG];                         // see R14
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg0_r  <= CFG0_RST;
      cfg1_r  <= CFG1_RST;
      flush_r <= 1'b0;
      clr_r   <= 1'b0;
    end else begin
      cfg0_r  <= cfg0_nxt;
      cfg1_r  <= cfg1_nxt;
      flush_r <= flush_nxt;
      clr_r   <= clr_nxt;
    end
  end

  assign ultra_ctrl    = {cfg0_r[C0_ULTRA_LO +: 3], cfg1_r[C1_ULTRA3]}; // see R4
  assign shadow_en     = cfg0_r[C0_SHADOW];                         // see R8
  assign dma_susp_en   = cfg1_r[C1_DMA_SUSP];                       // see R9
  assign stat_prio_en  = !cfg1_r[C1_STAT_OFF];                      // see R10
  assign ultra_ata_clr = xfer_end && !cfg1_r[C1_UDMA_KEEP];         // see R11 see R12
  assign seq_clear     = clr_r;                                     // see R14
  assign unmask_dtei   = cfg1_r[C1_UNMASK];

  // ----------------------------------------------------------------
  // 12-byte packet command fifo
  // ----------------------------------------------------------------
  logic [7:0] pcmd_r [HIC_PCMD_BYTES];
  logic [7:0] pcmd_nxt [HIC_PCMD_BYTES];
  logic [3:0] wptr_r, wptr_nxt;
  logic [3:0] rptr_r, rptr_nxt;
  logic       pkt_ok;

  assign pkt_ok = pkt_wr && atapi_mode && xfer_started              // see R2
                  && (wptr_r < 4'(HIC_PCMD_BYTES));

  always_comb begin
    pcmd_nxt = pcmd_r;
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    if (pkt_ok) begin
      pcmd_nxt[wptr_r] = pkt_byte;
      wptr_nxt         = wptr_r + 4'd1;
    end
    if (rd_pcmd && (rptr_r < wptr_r))
      rptr_nxt = rptr_r + 4'd1;                                     // see R1
    // a flush restarts both pointers even mid packet
    if (flush_r) begin
      wptr_nxt = 4'd0;                                              // see R13
      rptr_nxt = 4'd0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < HIC_PCMD_BYTES; i++)
        pcmd_r[i] <= 8'h00;
      wptr_r <= 4'd0;
      rptr_r <= 4'd0;
    end else begin
      pcmd_r <= pcmd_nxt;
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data, registered at the address phase
  // ----------------------------------------------------------------
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] ra;
  assign ra = {haddr[15:2], 2'b00};

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (ra)
        HIC_CFG0_ADDR: rdata_nxt = {16'h0000, cfg1_nxt, cfg0_nxt};
        // a fully read 12-byte packet leaves the read pointer one past the last slot, so it reads zero
        HIC_PCMD_ADDR: rdata_nxt = (rptr_nxt < 4'(HIC_PCMD_BYTES)) ? {24'h00_0000, pcmd_r[rptr_nxt]}
                                                                   : 32'h0000_0000; // see R1
        HIC_STAT_ADDR: rdata_nxt = {27'h000_0000, wptr_r, host_req};
        default:       rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rdata_nxt;
  end
  assign hrdata = rdata_r;

  // ----------------------------------------------------------------
  // threshold compare, live every clock
  // ----------------------------------------------------------------
  hic_thresh #(
    .FIFO_DEPTH (FIFO_DEPTH),
    .LVL_W      (LVL_W)
  ) u_thresh (
    .req_code (cfg0_r[C0_HREQ_LO +: 2]),                            // see R15
    .dyn_en   (cfg0_r[C0_DYN_EN]),
    .dyn_half (cfg0_r[C0_DYN_HALF]),
    .level    (fifo_level),
    .req_hit  (host_req),
    .dyn_prio (host_hi_prio)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  cfg_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cfg |=> cfg0_r == $past(hwdata[7:0])) else $error("cfg0 write lost"); // see R3
  unused_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg1_r[C1_UNUSED] == 1'b0) else $error("unused bit set");       // see R16
  flush_ptr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cfg && hwdata[8 + C1_FLUSH] |=> ##1 wptr_r == 4'd0) else $error("flush failed"); // see R13
  clear_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    seq_clear |=> !seq_clear || $past(wr_cfg)) else $error("clear not single"); // see R14
  pkt_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    pkt_wr && !(atapi_mode && xfer_started) && !flush_r |=> $stable(wptr_r))
    else $error("packet taken out of mode");                        // see R2
  udma_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cfg ##1 xfer_end |-> ultra_ata_clr == !$past(hwdata[8 + C1_UDMA_KEEP]))
    else $error("ultra cleared wrongly");                           // see R12
  stat_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cfg |=> stat_prio_en == !$past(hwdata[8 + C1_STAT_OFF])) else $error("stat prio mismatch"); // see R10
  dyn_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg0_r[C0_DYN_EN] |-> !host_hi_prio) else $error("priority while disabled"); // see R6
  shadow_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cfg |=> shadow_en == $past(hwdata[C0_SHADOW])) else $error("shadow mismatch"); // see R8
  pcmd_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_pcmd && rptr_r < wptr_r && !flush_r |=> rptr_r == $past(rptr_r) + 4'd1)
    else $error("packet read no advance");                          // see R1

  full_pkt_c: cover property (@(posedge clk) disable iff (!rst_n) wptr_r == 4'(HIC_PCMD_BYTES));
  flush_c:    cover property (@(posedge clk) disable iff (!rst_n) flush_r && wptr_r != 4'd0);
  udma_c:     cover property (@(posedge clk) disable iff (!rst_n) ultra_ata_clr);
  hiprio_c:   cover property (@(posedge clk) disable iff (!rst_n) host_hi_prio && host_req);
endmodule : hic_config

// >>> verif/hic_host_model.sv
// host-side packet byte source feeding the configuration block
`timescale 1ns/10ps
module hic_host_model (
  // clock
  input  wire logic       clk,
  // packet byte stream
  output logic            pkt_wr,
  output logic [7:0]      pkt_byte
);
  initial begin
    pkt_wr   = 1'b0;
    pkt_byte = 8'h5a;
  end

  // ------------------------------------------------
  // byte sender
  // ------------------------------------------------
  // strobe held across back-to-back bytes; idle data is inverted so it is never stale
  task automatic send(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      pkt_wr   <= 1'b1;
      pkt_byte <= 8'ha0 + 8'(i);
      @(posedge clk);
      if (gap > 0) begin
        pkt_wr   <= 1'b0;
        pkt_byte <= ~pkt_byte;
        repeat (gap) @(posedge clk);
      end
    end
    if (gap == 0) begin
      pkt_wr   <= 1'b0;
      pkt_byte <= ~pkt_byte;
    end
  endtask : send
endmodule : hic_host_model

// >>> verif/host_interface_config_test.sv
// self-checking bench for the host interface configuration block
`timescale 1ns/10ps
module host_interface_config_test import hic_pkg::*;;
  typedef struct packed {
    logic [7:0]  c0;
    logic [7:0]  c1;
    logic [7:0]  lvl;
    logic [3:0]  uc;
    logic [5:0]  fl;
    logic [15:0] rb;
  } hic_row_t;

  logic        clk, rst_n, hsel, hwrite, pkt_wr, atapi_mode, xfer_started, xfer_end;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  pkt_byte, fifo_level;
  logic        hreadyout, hresp, shadow_en, dma_susp_en, stat_prio_en, ultra_ata_clr;
  logic        seq_clear, unmask_dtei, host_req, host_hi_prio;
  logic [3:0]  ultra_ctrl;
  int          failures, checked;

  // flags: shadow, suspend, stat prio, unmask, request, high prio
  hic_row_t rows [10] = '{
    '{8'h00, 8'h00, 8'h40, 4'h0, 6'h0a, 16'h0000}, '{8'h00, 8'h00, 8'h3f, 4'h0, 6'h08, 16'h0000},
    '{8'h02, 8'h80, 8'h30, 4'h0, 6'h1a, 16'h8002}, '{8'h04, 8'h40, 8'h1f, 4'h0, 6'h00, 16'h4004},
    '{8'h06, 8'h04, 8'h5e, 4'h0, 6'h0e, 16'h0406}, '{8'h06, 8'h08, 8'h5d, 4'h0, 6'h08, 16'h0006},
    '{8'h08, 8'h01, 8'h20, 4'h1, 6'h09, 16'h0108}, '{8'h08, 8'h20, 8'h21, 4'h0, 6'h08, 16'h2008},
    '{8'h19, 8'h00, 8'h30, 4'h0, 6'h29, 16'h0019}, '{8'he9, 8'h01, 8'h31, 4'hf, 6'h28, 16'h01e9}};

  hic_config DUT (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .pkt_wr, .pkt_byte, .atapi_mode, .xfer_started, .xfer_end,
    .fifo_level, .ultra_ctrl, .shadow_en, .dma_susp_en, .stat_prio_en, .ultra_ata_clr, .seq_clear,
    .unmask_dtei, .host_req, .host_hi_prio);
  hic_host_model host (.clk, .pkt_wr, .pkt_byte);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // entered just after a rising edge, returns at the data-phase edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HIC_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : ahb

  task automatic summarize();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    summarize();
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    {rst_n, hsel, hwrite, atapi_mode, xfer_started, xfer_end} = '0;
    {haddr, hwdata} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    fifo_level = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      fifo_level <= rows[i].lvl;
      ahb(1'b1, 32'h0000_ff94, {16'h0000, rows[i].c1, rows[i].c0}, rd);
      @(negedge clk);
      chk(32'(ultra_ctrl), 32'(rows[i].uc));
      chk(32'({shadow_en, dma_susp_en, stat_prio_en, unmask_dtei, host_req, host_hi_prio}), 32'(rows[i].fl));
      @(posedge clk);
      ahb(1'b0, 32'h0000_ff94, 32'h0000_0000, rd);
      chk(rd, 32'(rows[i].rb));
    end
    $display("test table done");
    ahb(1'b1, 32'h0000_ff94, 32'h0000_0200, rd);
    @(negedge clk);
    chk(32'(seq_clear), 32'h1);
    @(negedge clk);
    chk(32'(seq_clear), 32'h0);
    @(posedge clk);
    xfer_end <= 1'b1;
    @(negedge clk);
    chk(32'(ultra_ata_clr), 32'h1);
    @(posedge clk);
    xfer_end <= 1'b0;
    ahb(1'b1, 32'h0000_ff94, 32'h0000_2000, rd);
    xfer_end <= 1'b1;
    @(negedge clk);
    chk(32'(ultra_ata_clr), 32'h0);
    @(posedge clk);
    xfer_end <= 1'b0;
    fifo_level <= 8'h00;
    $display("test strobes done");
    host.send(2, 0);
    ahb(1'b0, 32'h0000_ff9c, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    atapi_mode   <= 1'b1;
    xfer_started <= 1'b1;
    @(posedge clk);
    host.send(13, 1);
    ahb(1'b0, 32'h0000_ff9c, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0018);
    for (int i = 0; i < HIC_PCMD_BYTES; i++) begin
      ahb(1'b0, 32'h0000_ff98, 32'h0000_0000, rd);
      chk(rd, 32'h0000_00a0 + 32'(i));
    end
    repeat (2) begin
      ahb(1'b1, 32'h0000_ff94, 32'h0000_1000, rd);
      @(posedge clk);
      ahb(1'b0, 32'h0000_ff9c, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
      host.send(3, 0);
      ahb(1'b0, 32'h0000_ff9c, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0006);
    end
    $display("test packet done");
    ahb(1'b1, 32'h0000_ff90, 32'hffff_ffff, rd);
    ahb(1'b0, 32'h0000_ff90, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    ahb(1'b0, 32'h0000_ff94, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, 32'h0000_ff94, 32'h0000_e5ff, rd);
    @(negedge clk);
    chk(32'({dma_susp_en, shadow_en, stat_prio_en}), 32'h6);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b0, 32'h0000_ff94, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    chk(32'({stat_prio_en, host_hi_prio, shadow_en}), 32'h4);
    chk(32'({hreadyout, hresp}), 32'h2);
    xfer_started <= 1'b0;
    @(posedge clk);
    host.send(1, 0);
    ahb(1'b0, 32'h0000_ff9c, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
    summarize();
  end
endmodule : host_interface_config_test
